/* include/pm_consts.svh */
// Offsets, field positions and reset values for the port pin-function mux.
// Assumes a 32-bit classic Wishbone slave with byte addresses in adr.
`ifndef PM_CONSTS_SVH
`define PM_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PM_ADR_OUT 8'h00
`define PM_ADR_DIR 8'h04
`define PM_ADR_PIN 8'h08
`define PM_ADR_PULL 8'h0C
`define PM_ADR_CLAIM 8'h10
`define PM_ADR_SLEEP 8'h14
`define PM_ADR_PCEN 8'h18
`define PM_ADR_ISTAT 8'h1C
`define PM_ADR_IMASK 8'h20
`define PM_ADR_STATE 8'h24
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PM_BIT_TOP 5
`define PM_BIT_OSC_IN 3
`define PM_BIT_OSC_OUT 4
`define PM_BIT_SLP_EN 0
`define PM_BIT_SLP_PD 1
`define PM_BIT_IRQ_PC 0
`define PM_BIT_IRQ_WAKE 1
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define PM_RST_PORT 6'h00
`define PM_RST_IRQ 2'h0
`define PM_RST_DATA 32'h0000_0000
`define PM_CLK_NS 100
`define PM_RST_MIN_NS 50
`define PM_RST_MIN_CYC ((`PM_RST_MIN_NS + `PM_CLK_NS - 1) / `PM_CLK_NS)
`endif

/* include/pm_pkg.sv */
// Types shared by the port pin-function mux.
// Assumes the consts header carries the offsets, field positions and reset values; the encodings and widths stand here.
package pm_pkg;
  typedef enum logic [5:0] {
    PM_CLK_XTAL = 6'h01,
    PM_CLK_LFXTAL = 6'h02,
    PM_CLK_CERAMIC = 6'h04,
    PM_CLK_EXT_RC = 6'h08,
    PM_CLK_EXT_CLK = 6'h10,
    PM_CLK_INT_RC = 6'h20
  } pm_clk_opt_e;
  typedef enum logic [2:0] {
    PM_RUN = 3'h1,
    PM_IDLE = 3'h2,
    PM_PDOWN = 3'h4
  } pm_sleep_e;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pm_wbreq_s;
endpackage : pm_pkg

/* rtl/pm_port_mux.sv */
// Six-bit port with reset and oscillator pin sharing, pull-ups, pin-change
// detection and sleep control, behind a classic Wishbone slave.
// Assumes straps are static, mclk is the selected oscillator, wake_event
// comes from logic on mclk.
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pm_consts.svh"

module pm_port_mux #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire pm_pkg::pm_wbreq_s wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fuse_ext_reset_en,
  input wire pm_pkg::pm_clk_opt_e fuse_clk_opt,
  input wire logic [5:0] port_pin_i,
  output logic [5:0] port_pin_o,
  output logic [5:0] port_pin_oe_n,
  output logic [5:0] port_pullup_en,
  input wire logic wake_event,
  output logic chip_reset,
  output logic irq,
  output logic cpu_halt,
  output logic osc_stop,
  output logic periph_run
);

  // ----------------------------------------------------------------
  // Pin claims
  // ----------------------------------------------------------------
  function automatic logic [5:0] claim_mask(input pm_pkg::pm_clk_opt_e opt, input logic ext_rst);
    logic [5:0] m;
    m = 6'h00;
    m[`PM_BIT_TOP] = ext_rst;
    case (opt)
      pm_pkg::PM_CLK_XTAL, pm_pkg::PM_CLK_LFXTAL, pm_pkg::PM_CLK_CERAMIC: begin
        m[`PM_BIT_OSC_IN] = 1'b1;
        m[`PM_BIT_OSC_OUT] = 1'b1;
      end
      pm_pkg::PM_CLK_EXT_RC, pm_pkg::PM_CLK_EXT_CLK: begin
        m[`PM_BIT_OSC_IN] = 1'b1;
      end
      pm_pkg::PM_CLK_INT_RC: begin
        m[`PM_BIT_OSC_IN] = 1'b0;
      end
      default: begin
        m[`PM_BIT_OSC_IN] = 1'b1;
        m[`PM_BIT_OSC_OUT] = 1'b1;
      end
    endcase
    return m;
  endfunction : claim_mask

  wire logic [5:0] claim = claim_mask(fuse_clk_opt, fuse_ext_reset_en);
  wire logic [5:0] free = ~claim;

  // Reset pin acts without the clock, so any low pulse reaches the flops.
  wire logic ext_rst_act = fuse_ext_reset_en & ~port_pin_i[`PM_BIT_TOP];
  wire logic rst_int = rst | ext_rst_act;
  assign chip_reset = rst_int;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [5:0] out_q, out_d;
  logic [5:0] dir_q, dir_d;
  logic [4:0] pull_q, pull_d;
  logic [5:0] pcen_q, pcen_d;
  logic [1:0] istat_q, istat_d;
  logic [1:0] imask_q, imask_d;
  logic [5:0] sync1_q, sync2_q, prev_q;
  logic [2:0] arm_q;
  pm_pkg::pm_sleep_e slp_q, slp_d;
  logic ack_q;
  logic [31:0] dat_q, dat_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic req = wb_req.cyc & wb_req.stb & ~ack_q;
  // Writes commit at the edge where the master sees ack, while its request still stands.
  wire logic commit = wb_req.cyc & wb_req.stb & ack_q;
  wire logic wr = commit & wb_req.we & wb_req.sel[0];
  wire logic rd = req & ~wb_req.we;
  wire logic hit_out = wb_req.adr == `PM_ADR_OUT;
  wire logic hit_dir = wb_req.adr == `PM_ADR_DIR;
  wire logic hit_pin = wb_req.adr == `PM_ADR_PIN;
  wire logic hit_pull = wb_req.adr == `PM_ADR_PULL;
  wire logic hit_claim = wb_req.adr == `PM_ADR_CLAIM;
  wire logic hit_slp = wb_req.adr == `PM_ADR_SLEEP;
  wire logic hit_pcen = wb_req.adr == `PM_ADR_PCEN;
  wire logic hit_istat = wb_req.adr == `PM_ADR_ISTAT;
  wire logic hit_imask = wb_req.adr == `PM_ADR_IMASK;
  wire logic hit_state = wb_req.adr == `PM_ADR_STATE;
  wire logic [5:0] wdat = wb_req.dat[5:0];

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  wire logic [4:0] low_drive = dir_q[4:0] & free[4:0];
  wire logic top_drive = LARGE_VARIANT & dir_q[`PM_BIT_TOP] & ~out_q[`PM_BIT_TOP]
                         & free[`PM_BIT_TOP];
  assign port_pin_o = {1'b0, out_q[4:0]};
  assign port_pin_oe_n = ~{top_drive, low_drive} | {6{rst_int}};
  assign port_pullup_en = {1'b0, pull_q & free[4:0] & ~{5{rst_int}}};

  // ----------------------------------------------------------------
  // Pin input and change detection
  // ----------------------------------------------------------------
  wire logic [5:0] pin_rd = sync2_q & free;
  // Change detection waits until the previous-sample flop holds a real pin value after reset.
  wire logic [5:0] chg = (sync2_q ^ prev_q) & pcen_q & free & {6{arm_q[2]}};
  wire logic pc_evt = |chg;
  wire logic wake_req = irq | wake_event;
  wire logic leave_sleep = (slp_q != pm_pkg::PM_RUN) & wake_req;

  always_ff @(posedge mclk or posedge rst_int) begin
    if (rst_int) begin
      sync1_q <= `PM_RST_PORT;
      sync2_q <= `PM_RST_PORT;
      prev_q <= `PM_RST_PORT;
      arm_q <= 3'h0;
    end else begin
      sync1_q <= port_pin_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      arm_q <= {arm_q[1:0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  assign out_d = (wr & hit_out) ? wdat : out_q;
  assign dir_d = (wr & hit_dir) ? wdat : dir_q;
  assign pull_d = (wr & hit_pull) ? wdat[4:0] : pull_q;
  assign pcen_d = (wr & hit_pcen) ? wdat : pcen_q;
  assign imask_d = (wr & hit_imask) ? wdat[1:0] : imask_q;
  wire logic [1:0] istat_clr = (wr & hit_istat) ? wdat[1:0] : 2'h0;
  wire logic [1:0] istat_set = {leave_sleep, pc_evt};
  assign istat_d = (istat_q & ~istat_clr) | istat_set;
  assign irq = |(istat_q & imask_q);

  wire logic [31:0] rd_word =
    hit_out ? {26'h0, out_q} :
    hit_dir ? {26'h0, dir_q} :
    hit_pin ? {26'h0, pin_rd} :
    hit_pull ? {27'h0, pull_q} :
    hit_claim ? {26'h0, claim} :
    hit_slp ? {30'h0, slp_q == pm_pkg::PM_PDOWN, slp_q != pm_pkg::PM_RUN} :
    hit_pcen ? {26'h0, pcen_q} :
    hit_istat ? {30'h0, istat_q} :
    hit_imask ? {30'h0, imask_q} :
    hit_state ? {29'h0, slp_q} :
    `PM_RST_DATA;
  assign dat_d = rd ? rd_word : `PM_RST_DATA;

  // ----------------------------------------------------------------
  // Sleep control
  // ----------------------------------------------------------------
  wire logic slp_go = wr & hit_slp & wdat[`PM_BIT_SLP_EN];
  always_comb begin
    slp_d = slp_q;
    case (slp_q)
      pm_pkg::PM_RUN: begin
        if (slp_go & ~wake_req) begin
          slp_d = wdat[`PM_BIT_SLP_PD] ? pm_pkg::PM_PDOWN : pm_pkg::PM_IDLE;
        end
      end
      pm_pkg::PM_IDLE: begin
        if (wake_req) begin
          slp_d = pm_pkg::PM_RUN;
        end
      end
      pm_pkg::PM_PDOWN: begin
        if (wake_req) begin
          slp_d = pm_pkg::PM_RUN;
        end
      end
      default: begin
        slp_d = pm_pkg::PM_RUN;
      end
    endcase
  end

  assign cpu_halt = slp_q != pm_pkg::PM_RUN;
  assign osc_stop = slp_q == pm_pkg::PM_PDOWN;
  assign periph_run = slp_q != pm_pkg::PM_PDOWN;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst_int) begin
    if (rst_int) begin
      out_q <= `PM_RST_PORT;
      dir_q <= `PM_RST_PORT;
      pull_q <= 5'h00;
      pcen_q <= `PM_RST_PORT;
      istat_q <= `PM_RST_IRQ;
      imask_q <= `PM_RST_IRQ;
      slp_q <= pm_pkg::PM_RUN;
      ack_q <= 1'b0;
      dat_q <= `PM_RST_DATA;
    end else begin
      out_q <= out_d;
      dir_q <= dir_d;
      pull_q <= pull_d;
      pcen_q <= pcen_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      slp_q <= slp_d;
      ack_q <= req;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_dir_write;
    wr && hit_dir;
  endsequence

  sequence s_enter_idle;
    slp_q == pm_pkg::PM_RUN && slp_go && !wdat[`PM_BIT_SLP_PD] && !wake_req;
  endsequence

  sequence s_enter_pdown;
    slp_q == pm_pkg::PM_RUN && slp_go && wdat[`PM_BIT_SLP_PD] && !wake_req;
  endsequence

  property p_lower_dir;
    @(posedge mclk) disable iff (rst_int)
    s_dir_write ##1 $stable(claim) |->
      port_pin_oe_n[4:0] == ~($past(wb_req.dat[4:0]) & free[4:0]);
  endproperty
  a_lower_dir: assert property (p_lower_dir) else $error("lower pin direction wrong");

  property p_top_no_high;
    @(posedge mclk) disable iff (rst_int)
    !port_pin_oe_n[`PM_BIT_TOP] |-> LARGE_VARIANT && !port_pin_o[`PM_BIT_TOP];
  endproperty
  a_top_no_high: assert property (p_top_no_high) else $error("top pin driven high");

  property p_reset_tristate;
    @(posedge mclk) rst_int |-> port_pin_oe_n == 6'h3F && port_pullup_en == 6'h00;
  endproperty
  a_reset_tristate: assert property (p_reset_tristate) else $error("pin driven in reset");

  property p_ext_reset_claim;
    @(posedge mclk) disable iff (rst_int)
    fuse_ext_reset_en |-> port_pin_oe_n[`PM_BIT_TOP] && !pin_rd[`PM_BIT_TOP];
  endproperty
  a_ext_reset_claim: assert property (p_ext_reset_claim) else $error("reset pin used");

  property p_osc_claim;
    @(posedge mclk) disable iff (rst_int)
    fuse_clk_opt != pm_pkg::PM_CLK_INT_RC |->
      port_pin_oe_n[`PM_BIT_OSC_IN] && !port_pullup_en[`PM_BIT_OSC_IN];
  endproperty
  a_osc_claim: assert property (p_osc_claim) else $error("oscillator pin used");

  property p_free_pins;
    @(posedge mclk) disable iff (rst_int)
    fuse_clk_opt == pm_pkg::PM_CLK_INT_RC && !fuse_ext_reset_en |-> claim == 6'h00;
  endproperty
  a_free_pins: assert property (p_free_pins) else $error("free pin claimed");

  property p_ext_reset_low;
    @(posedge mclk) fuse_ext_reset_en && !port_pin_i[`PM_BIT_TOP] |-> chip_reset;
  endproperty
  a_ext_reset_low: assert property (p_ext_reset_low) else $error("reset level missed");

  property p_idle;
    @(posedge mclk) disable iff (rst_int)
    s_enter_idle |=> cpu_halt && periph_run && !osc_stop;
  endproperty
  a_idle: assert property (p_idle) else $error("idle sleep wrong");

  property p_pdown;
    @(posedge mclk) disable iff (rst_int)
    s_enter_pdown ##1 !wake_req |=> osc_stop && $stable(out_q) && $stable(dir_q);
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down wrong");

  property p_pin_change;
    @(posedge mclk) disable iff (rst_int)
    pc_evt |=> istat_q[`PM_BIT_IRQ_PC] ##1
      (istat_q[`PM_BIT_IRQ_PC] || $past(istat_clr[`PM_BIT_IRQ_PC]));
  endproperty
  a_pin_change: assert property (p_pin_change) else $error("pin change lost");

  property p_wake;
    @(posedge mclk) disable iff (rst_int)
    cpu_halt && wake_req |=> !cpu_halt && istat_q[`PM_BIT_IRQ_WAKE];
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed");

  property p_claim_read;
    @(posedge mclk) disable iff (rst_int)
    rd && hit_pin ##0 $stable(claim) |=> wb_ack_o && (wb_dat_o[5:0] & claim) == 6'h00;
  endproperty
  a_claim_read: assert property (p_claim_read) else $error("claimed pin read");

endmodule : pm_port_mux

/* verif/pm_board.sv */
// Board-side model of the six port pins: external drivers, pull-ups, released lines.
// Assumes the bench sets the board drive and the design sets the pad controls.
`timescale 1ns/1ps
module pm_board (
  input wire logic [5:0] pin_o,
  input wire logic [5:0] oe_n,
  input wire logic [5:0] pu_en,
  input wire logic [5:0] drv_en,
  input wire logic [5:0] drv_val,
  output logic [5:0] lvl
);
  // ----------------------------------------------------------------
  // Pin level
  // ----------------------------------------------------------------
  // A line that nobody drives and nothing pulls up shows the inverse of the board value.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!oe_n[i])
        lvl[i] = pin_o[i];
      else if (drv_en[i])
        lvl[i] = drv_val[i];
      else if (pu_en[i])
        lvl[i] = 1'b1;
      else
        lvl[i] = ~drv_val[i];
    end
  end
endmodule : pm_board

/* verif/pm_port_mux_bench.sv */
// Self-checking bench for the port pin-function mux over classic Wishbone.
// Assumes the board model on the pins and a 10 MHz clock.
`timescale 1ns/1ps
`include "pm_consts.svh"
module pm_port_mux_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  pm_pkg::pm_wbreq_s req = '0;
  logic [31:0] rdat, d;
  logic ack, crst, irq, halt, ostop, prun;
  logic ext_en = 1'b0;
  pm_pkg::pm_clk_opt_e copt = pm_pkg::PM_CLK_INT_RC;
  logic [5:0] lvl, po, oen, pu, cm, oen_s;
  logic [5:0] drv_en = 6'h24;
  logic [5:0] drv_val = 6'h20;
  logic wake = 1'b0;
  int err_count = 0;
  int checks_done = 0;
  pm_pkg::pm_clk_opt_e opts[6] = '{pm_pkg::PM_CLK_XTAL, pm_pkg::PM_CLK_LFXTAL,
    pm_pkg::PM_CLK_CERAMIC, pm_pkg::PM_CLK_EXT_RC, pm_pkg::PM_CLK_EXT_CLK, pm_pkg::PM_CLK_INT_RC};
  logic [5:0] cms[6] = '{6'h18, 6'h18, 6'h18, 6'h08, 6'h08, 6'h00};
  pm_port_mux dut (.mclk(mclk), .rst(rst), .wb_req(req), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fuse_ext_reset_en(ext_en), .fuse_clk_opt(copt), .port_pin_i(lvl), .port_pin_o(po),
    .port_pin_oe_n(oen), .port_pullup_en(pu), .wake_event(wake), .chip_reset(crst),
    .irq(irq), .cpu_halt(halt), .osc_stop(ostop), .periph_run(prun));
  pm_board board (.pin_o(po), .oe_n(oen), .pu_en(pu), .drv_en(drv_en), .drv_val(drv_val),
    .lvl(lvl));
  pm_port_mux #(.LARGE_VARIANT(1'b0)) dut_small (.mclk(mclk), .rst(rst), .wb_req(req),
    .wb_dat_o(), .wb_ack_o(), .fuse_ext_reset_en(ext_en), .fuse_clk_opt(copt),
    .port_pin_i(lvl), .port_pin_o(), .port_pin_oe_n(oen_s), .port_pullup_en(),
    .wake_event(wake), .chip_reset(), .irq(), .cpu_halt(), .osc_stop(), .periph_run());
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  initial begin
    forever #50 mclk = ~mclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    req <= '{1'b1, 1'b1, we, a, 4'hF, wd};
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge mclk);
    if (n == 20) begin
      err_count++;
      end_sim();
    end
    d = rdat;
    req <= '0;
  endtask : wb
  task automatic do_rst(input int n, input logic e, input pm_pkg::pm_clk_opt_e o);
    @(posedge mclk);
    rst <= 1'b1;
    ext_en <= e;
    copt <= o;
    repeat (n) @(posedge mclk);
    chk({oen, pu, crst, prun}, {6'h3F, 6'h00, 1'b1, 1'b1});
    rst <= 1'b0;
  endtask : do_rst
  task automatic settle();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  // The top pin is pulled low for 60 ns, off the clock edges.
  task automatic pulse(input logic exp);
    @(posedge mclk);
    #20 drv_val[5] = 1'b0;
    #30 chk({crst, oen | {6{~exp}}}, {exp, 6'h3F});
    #30 drv_val[5] = 1'b1;
  endtask : pulse
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    do_rst(6, 1'b0, pm_pkg::PM_CLK_INT_RC);
    wb(0, 8'h3C, 0);
    chk(d, 0);
    pulse(1'b0);
    wb(1, `PM_ADR_DIR, 32'h3F);
    wb(1, `PM_ADR_OUT, 32'h15);
    settle();
    chk({oen, po}, {6'h00, 6'h15});
    chk(oen_s, 6'h20);
    wb(0, `PM_ADR_PIN, 0);
    chk(d, 32'h15);
    wb(1, `PM_ADR_OUT, 32'h35);
    settle();
    chk({oen, po}, {6'h20, 6'h15});
    wb(1, `PM_ADR_DIR, 0);
    wb(1, `PM_ADR_PULL, 32'h0A);
    settle();
    chk({oen, pu}, {6'h3F, 6'h0A});
    $display("port pins done");
    do_rst(2, 1'b1, pm_pkg::PM_CLK_INT_RC);
    wb(1, `PM_ADR_DIR, 32'h3F);
    settle();
    chk(oen, 6'h20);
    pulse(1'b1);
    settle();
    wb(0, `PM_ADR_DIR, 0);
    chk(d, 0);
    $display("external reset done");
    for (int e = 0; e < 2; e++) begin
      for (int i = 0; i < 6; i++) begin
        cm = cms[i] | (e[0] ? 6'h20 : 6'h00);
        do_rst(2, e[0], opts[i]);
        wb(1, `PM_ADR_DIR, 32'h3F);
        wb(1, `PM_ADR_OUT, 32'h3F);
        wb(0, `PM_ADR_CLAIM, 0);
        chk(d, {26'h0, cm});
        settle();
        chk(oen, cm | 6'h20);
        wb(0, `PM_ADR_PIN, 0);
        chk(d, {26'h0, ~cm});
      end
    end
    $display("pin claims done");
    do_rst(2, 1'b0, pm_pkg::PM_CLK_INT_RC);
    wb(1, `PM_ADR_PCEN, 32'h04);
    wb(1, `PM_ADR_ISTAT, 32'h03);
    drv_val[2] <= 1'b1;
    repeat (5) @(posedge mclk);
    wb(0, `PM_ADR_ISTAT, 0);
    chk(d, 32'h1);
    chk(irq, 1'b0);
    wb(1, `PM_ADR_IMASK, 32'h03);
    settle();
    chk(irq, 1'b1);
    wb(1, `PM_ADR_ISTAT, 32'h01);
    settle();
    chk(irq, 1'b0);
    $display("pin change done");
    for (int m = 0; m < 2; m++) begin
      wb(1, `PM_ADR_SLEEP, {30'h0, m[0], 1'b1});
      @(negedge mclk);
      chk({halt, ostop, prun}, m ? 3'b110 : 3'b101);
      wb(0, `PM_ADR_STATE, 0);
      chk(d, m ? 32'h4 : 32'h2);
      wb(0, `PM_ADR_SLEEP, 0);
      chk(d, m ? 32'h3 : 32'h1);
      @(posedge mclk);
      if (m)
        drv_val[2] <= ~drv_val[2];
      else
        wake <= 1'b1;
      @(posedge mclk);
      wake <= 1'b0;
      for (int n = 0; halt !== 1'b0; n++) begin
        if (n == 10) begin
          err_count++;
          end_sim();
        end
        @(posedge mclk);
      end
      wb(0, `PM_ADR_ISTAT, 0);
      chk(d, m ? 32'h3 : 32'h2);
      wb(1, `PM_ADR_ISTAT, 32'h03);
    end
    $display("sleep done");
    end_sim();
  end
endmodule : pm_port_mux_bench
